// ===== sld_top.sv
// Status indicator and boot progress code display with APB registers
//
// Overview of operation
// - Any fatal condition lights the indicator amber solid.
// - Non-fatal alarms blink the indicator amber.
// - Booted and ready on main power with no alarm or degradation gives green solid.
// - Degraded conditions blink the indicator green.
// - Indicator dark when main power absent and no condition active.
// - Each written progress code appears on the diagnostic bank at once.
// - Diagnostic LED seven carries the code MSB, LED zero the LSB.
// - Last written progress code holds on the LEDs until the next write.
//
// Register map, one 32-bit word each, narrow fields in the low bits
//   0x000 control: bit0 system ready, bit1 main power, bit2 redundant fans
//   0x004 conditions, read only, the raw condition levels
//   0x008 progress code, read and write
//   0x00C status, read only: amber, green, then the indicator state
// Writes land at the access edge; reads need no wait state.
// Unmapped offsets answer with an error and writes to them are dropped.
// Fan redundancy conditions count only when the redundant bit is set.
// Green solid needs both ready and main power, so a dark panel means no power or not ready.
`timescale 1ns/1ps
`default_nettype none
module sld_top
  import sld_pkg::*;
#(
  parameter int BLINK_HALF = SLD_BLINK_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Platform conditions
  input  wire sld_cond_t   cond,
  // Front panel indicator
  output sld_led_t         status_led,
  // Diagnostic LED bank, bit n drives LED n
  output logic [7:0]       diag_led
);

  // Register state
  logic [2:0]  ctrl_q;
  logic [7:0]  code_q;
  logic [31:0] prdata_q;
  logic        slverr_q;
  // Indicator path
  sld_state_t  state_d;
  sld_state_t  state_q;
  sld_led_t    led_q;
  logic        phase;
  logic        fatal;
  logic        alarm;
  logic        degraded;
  // Bus decode and control fields
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic        wr_ctrl;
  logic        wr_code;
  logic        ready_bit;
  logic        power_on;
  logic        redundant;

  // Decode one register offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // Any of the four register words
  function automatic logic mapped(input logic [11:0] a);
    return hit(a, SLD_CTRL_OFS) || hit(a, SLD_COND_OFS) ||
           hit(a, SLD_CODE_OFS) || hit(a, SLD_STATUS_OFS);
  endfunction

  // Lamp drive for a state; a blinking lamp is lit while the phase is low
  function automatic sld_led_t led_drive(input sld_state_t s, input logic ph);
    sld_led_t l;
    l = '0;
    unique case (s)
      SLD_OFF:         l = '0;
      SLD_GREEN_SOLID: l.green = 1'b1;
      SLD_GREEN_BLINK: l.green = ~ph;
      SLD_AMBER_BLINK: l.amber = ~ph;
      SLD_AMBER_SOLID: l.amber = 1'b1;
    endcase
    return l;
  endfunction

  // Slave answers in the access cycle, no wait states
  assign pready  = 1'b1;
  assign pslverr = slverr_q;
  assign prdata  = prdata_q;
  // Writes land at the access edge, the one at which pready is sampled
  assign wr_en   = psel && penable && pready && pwrite;
  // Read data is staged in the setup cycle so it stands through the access
  assign rd_en   = psel && !penable && !pwrite;
  assign addr_ok = mapped(paddr);

  // Per-register write strobes; a clear pstrb[0] drops the write
  assign wr_ctrl = wr_en && hit(paddr, SLD_CTRL_OFS) && pstrb[0];
  assign wr_code = wr_en && hit(paddr, SLD_CODE_OFS) && pstrb[0];

  // Control fields
  assign ready_bit = ctrl_q[SLD_CTRL_READY_BIT];
  assign power_on  = ctrl_q[SLD_CTRL_PWR_BIT];
  assign redundant = ctrl_q[SLD_CTRL_REDUN_BIT];

  // Control register write
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= SLD_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      code_q <= SLD_CODE_RST;
    end else if (wr_code) begin
      code_q <= pwdata[7:0];
    end
  end

  // Error flag for unmapped offsets, staged in the setup cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slverr_q <= 1'b0;
    end else if (psel && !penable) begin
      slverr_q <= !addr_ok;
    end
  end

  // Read data staged in the setup cycle; writes and misses read zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata_q <= 32'h0;
    end else if (rd_en) begin
      unique case (1'b1)
        hit(paddr, SLD_CTRL_OFS):   prdata_q <= {29'h0, ctrl_q};
        hit(paddr, SLD_COND_OFS):   prdata_q <= {12'h0, cond};
        hit(paddr, SLD_CODE_OFS):   prdata_q <= {24'h0, code_q};
        hit(paddr, SLD_STATUS_OFS): prdata_q <= {27'h0, led_q, state_q};
        default:                    prdata_q <= 32'h0;
      endcase
    end else if (psel && !penable) begin
      prdata_q <= 32'h0;
    end
  end

  // fatal set, fan loss only counts on redundant systems
  assign fatal = cond.thermal_trip | cond.nonrec_temp | cond.nonrec_volt |
                 cond.power_fault | cond.mem_uncorrectable |
                 (cond.fan_redun_lost_insuff & redundant);
  assign alarm = cond.catastrophic_error_signal | cond.crit_temp | cond.crit_volt |
                 cond.crit_fan | cond.regulator_hot | cond.mgmt_interrupt_timeout |
                 cond.dimm_ce_threshold;
  assign degraded = cond.noncrit_temp | cond.noncrit_volt | cond.noncrit_fan |
                    (cond.fan_redun_lost_suff & redundant) | cond.psu_predictive_fail |
                    cond.mem_not_all_usable | cond.chan_ce_threshold;

  always_comb begin
    if (fatal) begin
      state_d = SLD_AMBER_SOLID;
    end else if (alarm) begin
      state_d = SLD_AMBER_BLINK;
    end else if (degraded) begin
      state_d = SLD_GREEN_BLINK;
    end else if (ready_bit && power_on) begin
      state_d = SLD_GREEN_SOLID;
    // dark otherwise: no condition, and ready or main power clear
    end else begin
      state_d = SLD_OFF;
    end
  end

  // Blink phase source
  sld_blink #(
    .HALF_CYCLES (BLINK_HALF)
  ) u_blink (
    .clk     (clk),
    .reset_n (reset_n),
    .phase_q (phase)
  );

  // Indicator state register, read back through the status word
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= SLD_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // Lamp drive register, follows the chosen state on the same edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      led_q <= '0;
    end else begin
      led_q <= led_drive(state_d, phase);
    end
  end

  assign status_led = led_q;
  assign diag_led = code_q;

endmodule
`default_nettype wire

// ===== sld_pkg.sv
// Shared constants and types for the status LED and progress code display
package sld_pkg;

  // Register byte offsets
  localparam logic [11:0] SLD_CTRL_OFS   = 12'h000;
  localparam logic [11:0] SLD_COND_OFS   = 12'h004;
  localparam logic [11:0] SLD_CODE_OFS   = 12'h008;
  localparam logic [11:0] SLD_STATUS_OFS = 12'h00C;

  // Field positions of the control register
  localparam int SLD_CTRL_READY_BIT = 0;
  localparam int SLD_CTRL_PWR_BIT   = 1;
  localparam int SLD_CTRL_REDUN_BIT = 2;

  // Reset values
  localparam logic [2:0] SLD_CTRL_RST = 3'h0;
  localparam logic [7:0] SLD_CODE_RST = 8'h00;

  // Blink timing: half period in ms and its cycle count at 10 MHz
  localparam int SLD_CLK_HZ       = 10000000;
  localparam int SLD_BLINK_HALF_MS = 500;
  localparam int SLD_BLINK_CYCLES = SLD_CLK_HZ / 1000 * SLD_BLINK_HALF_MS;

  // Indicator states, lowest to highest precedence
  typedef enum logic [2:0] {
    SLD_OFF,
    SLD_GREEN_SOLID,
    SLD_GREEN_BLINK,
    SLD_AMBER_BLINK,
    SLD_AMBER_SOLID
  } sld_state_t;

  // Platform condition inputs
  typedef struct packed {
    logic thermal_trip;
    logic nonrec_temp;
    logic nonrec_volt;
    logic power_fault;
    logic fan_redun_lost_insuff;
    logic mem_uncorrectable;
    logic catastrophic_error_signal;
    logic crit_temp;
    logic crit_volt;
    logic crit_fan;
    logic regulator_hot;
    logic mgmt_interrupt_timeout;
    logic dimm_ce_threshold;
    logic noncrit_temp;
    logic noncrit_volt;
    logic noncrit_fan;
    logic fan_redun_lost_suff;
    logic psu_predictive_fail;
    logic mem_not_all_usable;
    logic chan_ce_threshold;
  } sld_cond_t;

  // Drive of the two-colour indicator
  typedef struct packed {
    logic amber;
    logic green;
  } sld_led_t;

endpackage

// ===== sld_blink.sv
// Free-running blink phase generator
`timescale 1ns/1ps
`default_nettype none
module sld_blink
  import sld_pkg::*;
#(
  parameter int HALF_CYCLES = SLD_BLINK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Phase output
  output logic      phase_q
);

  logic [31:0] cnt_q;

  // Count half periods and toggle the phase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q   <= 32'h0;
      phase_q <= 1'b0;
    end else if (cnt_q == 32'(HALF_CYCLES - 1)) begin
      cnt_q   <= 32'h0;
      phase_q <= ~phase_q;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

endmodule
`default_nettype wire

// ===== sld_top_assertions.sv
// Port checks for the status indicator, diagnostic bank and APB slave
`timescale 1ns/1ps
`default_nettype none
module sld_top_assertions
  import sld_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // APB side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // Conditions and lamps
  input wire sld_cond_t   cond,
  input wire sld_led_t    status_led,
  input wire logic [7:0]  diag_led
);
  // Severity groups, fan redundancy bits left out
  logic fatal, alarm, degr, wr_code;
  assign fatal = |{cond[19:16], cond[14]};
  assign alarm = |cond[13:7];
  assign degr = |{cond[6:4], cond[2:0]};
  assign wr_code = psel && penable && pready && pwrite && paddr == SLD_CODE_OFS && pstrb[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_fatal_solid: assert property (fatal |=> status_led == 2'b10)
    else $error("fatal condition not amber solid");
  a_alarm_no_green: assert property (!fatal && alarm |=> !status_led.green)
    else $error("alarm shows green");
  a_degr_no_amber: assert property (!fatal && !cond[15] && !alarm && degr |=> !status_led.amber)
    else $error("degraded shows amber");
  a_idle_no_amber: assert property (cond == '0 |=> !status_led.amber)
    else $error("amber with no condition");
  a_code_shown: assert property (wr_code |=> diag_led == $past(pwdata[7:0]))
    else $error("code not shown");
  a_code_held: assert property (!wr_code |=> $stable(diag_led))
    else $error("code changed without write");
  a_no_wait: assert property (psel && penable |-> pready)
    else $error("wait state seen");
  a_bad_addr: assert property (psel && penable && paddr > SLD_STATUS_OFS |-> pslverr)
    else $error("unmapped access not flagged");
endmodule

bind sld_top sld_top_assertions u_chk (
  .clk        (clk),
  .reset_n    (reset_n),
  .psel       (psel),
  .penable    (penable),
  .pwrite     (pwrite),
  .paddr      (paddr),
  .pwdata     (pwdata),
  .pstrb      (pstrb),
  .pready     (pready),
  .pslverr    (pslverr),
  .cond       (cond),
  .status_led (status_led),
  .diag_led   (diag_led)
);
`default_nettype wire

// ===== sld_panel_model.sv
// Platform condition sources feeding the block
`timescale 1ns/1ps
`default_nettype none
module sld_panel_model
  import sld_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Raw sensor levels
  input  wire logic [19:0] src,
  // Condition drive
  output sld_cond_t        cond
);
  // Monitors latch their levels one edge late
  always_ff @(posedge clk) begin
    cond <= src;
  end
endmodule
`default_nettype wire

// ===== sld_top_tb.sv
// Self-checking bench for the status indicator and code display
`timescale 1ns/1ps
`default_nettype none
module sld_top_tb;
  import sld_pkg::*;
  typedef struct packed {logic [2:0] c; logic [19:0] s; sld_state_t e;} sld_row_t;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [19:0] src = '0;
  logic [7:0] diag_led;
  sld_cond_t cond;
  sld_led_t status_led;
  int n_errors = 0, checked = 0, cycles = 0, lit;
  sld_row_t rows [7] = '{'{3'h0, 20'h0, SLD_OFF}, '{3'h3, 20'h0, SLD_GREEN_SOLID},
    '{3'h1, 20'h0, SLD_OFF}, '{3'h3, 20'h08008, SLD_GREEN_SOLID},
    '{3'h1, 20'h82040, SLD_AMBER_SOLID}, '{3'h1, 20'h02041, SLD_AMBER_BLINK},
    '{3'h0, 20'h00002, SLD_GREEN_BLINK}};
  sld_panel_model u_panel (.clk(clk), .src(src), .cond(cond));
  sld_top #(.BLINK_HALF(4)) dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cond(cond), .status_led(status_led),
    .diag_led(diag_led));
  // Clock
  initial forever #50 clk = ~clk;
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // One APB transfer, result taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [2:0] c, input logic [19:0] s, input sld_state_t e);
    apb(1'b1, SLD_CTRL_OFS, {29'h0, c});
    src <= s;
    repeat (3) @(posedge clk);
    apb(1'b0, SLD_STATUS_OFS, 32'h0);
    chk(rd[2:0] === e, "state");
    if (e inside {SLD_OFF, SLD_GREEN_SOLID, SLD_AMBER_SOLID})
      chk(status_led === (e == SLD_OFF ? 2'b00 : e == SLD_GREEN_SOLID ? 2'b01 : 2'b10), "led");
  endtask
  task automatic conclude();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    chk(diag_led === 8'h00 && status_led === 2'b00, "reset");
    foreach (rows[i]) run(rows[i].c, rows[i].s, rows[i].e);
    for (int i = 0; i < 20; i++)
      run(3'h5, 20'h1 << i, i > 13 ? SLD_AMBER_SOLID : i > 6 ? SLD_AMBER_BLINK : SLD_GREEN_BLINK);
    // Alarm only: amber lit for half of any eight cycles
    src <= 20'h02000;
    repeat (4) @(posedge clk);
    lit = 0;
    repeat (8) @(negedge clk) lit += status_led.amber;
    chk(lit == 4 && status_led.green === 1'b0, "blink");
    // Degraded only: green lit for half of any eight cycles
    @(posedge clk);
    src <= 20'h00040;
    repeat (4) @(posedge clk);
    lit = 0;
    repeat (8) @(negedge clk) lit += status_led.green;
    chk(lit == 4 && status_led.amber === 1'b0, "green blink");
    apb(1'b1, SLD_CODE_OFS, 32'h1E);
    @(posedge clk);
    chk(diag_led === 8'h1E, "code");
    pstrb <= 4'h0;
    apb(1'b1, SLD_CODE_OFS, 32'h77);
    pstrb <= 4'hF;
    apb(1'b1, 12'h010, 32'h33);
    chk(err === 1'b1 && diag_led === 8'h1E, "hold");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    chk(diag_led === 8'h00, "rerun");
    apb(1'b0, SLD_CTRL_OFS, 32'h0);
    chk(rd[2:0] === SLD_CTRL_RST && err === 1'b0, "ctrl reset");
    conclude();
  end
endmodule
`default_nettype wire
